// ===== verilog/fchbd_host_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "fchbd_defines.svh"
// How it works
// - Memory personality drives read data while the read strobe is low.
// - I/O personality uses read strobe only for info structure and config.
// - Memory personality: ready_busy_n high when ready, low when busy.
// - ready_busy_n stays low until the internal reset sequence finishes.
// - With reset input tied high from power-up, never signal busy.
// - I/O personality reuses ready_busy_n as active-low interrupt request.
// - I/O interrupt is either a brief low pulse or a held low level.
// - Disk personality interrupt request is active high.
// - Eleven address lines plus space select pick the register target.
// - Disk personality uses three low address lines for eight registers.
// - Both enables select the card; second enable means odd byte.
// - First enable alone picks even or odd byte from address bit zero.
// - Odd bytes reach an eight-bit host on the low data lines.
// - First disk chip select picks the task-file register group.
// - Second disk chip select picks alternate status and device control.
// - Memory personality: space select high is common memory, low is attribute memory.
// - Disk task-file uses low byte; data transfers use sixteen bits.
// - I/O write data is captured on the rising edge of the write strobe.
module fchbd_host_port
  import fchbd_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Host pins, all active low except address.
  input wire logic card_reset_pin,
  input wire logic read_strobe_n,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic write_enable_n,
  input wire logic space_select_n,
  input wire logic card_enable_low_n,
  input wire logic card_enable_high_n,
  input wire logic taskfile_select_n,
  input wire logic control_block_select_n,
  input wire logic [`FCHBD_ADDR_W-1:0] address,
  // Host data bus as three signals.
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic [15:0] data_oe,
  // Status pins toward the host.
  output logic ready_busy_n,
  output logic disk_interrupt,
  // Card side controls.
  input wire logic io_configured,
  input wire logic irq_level_mode,
  input wire logic irq_event,
  input wire logic irq_active,
  input wire logic card_busy,
  input wire logic data_transfer,
  input wire logic [15:0] read_word,
  // Decoded access toward the card.
  output fchbd_mode_t mode,
  output fchbd_target_t target,
  output fchbd_lane_t lane,
  output logic [`FCHBD_ADDR_W-1:0] reg_address,
  output logic write_pulse,
  output logic [15:0] write_word
);
  // ---------------------------------------------------------------------
  // Input synchronisers.
  // ---------------------------------------------------------------------
  logic [8:0] raw_pins;
  logic [8:0] synced;
  logic rd_n, iord_n, io_write_strobe_n_n, we_n, reg_n, ce1_n, ce2_n, cs0_n, cs1_n;
  logic io_write_strobe_n_prev, we_prev;

  assign raw_pins = {read_strobe_n, io_read_strobe_n, io_write_strobe_n,
                     write_enable_n, space_select_n, card_enable_low_n,
                     card_enable_high_n, taskfile_select_n,
                     control_block_select_n};

  fchbd_sync #(.WIDTH(9)) fchbd_sync_i (
    .clock(clock),
    .rst(rst),
    .async_in(raw_pins),
    .sync_out(synced)
  );

  assign {rd_n, iord_n, io_write_strobe_n_n, we_n, reg_n, ce1_n, ce2_n, cs0_n,
          cs1_n} = synced;

  // ---------------------------------------------------------------------
  // Personality and reset sequence.
  // ---------------------------------------------------------------------
  logic [15:0] reset_count;
  logic reset_done;
  logic reset_seen;
  logic mode_latched;

  always_ff @(posedge clock) begin
    if (rst) begin
      mode <= fchbd_mode_memory;
      mode_latched <= 1'b0;
    end else if (!mode_latched && reset_count == `FCHBD_SYNC_SETTLE) begin
      mode_latched <= 1'b1;
      if (!rd_n) begin
        mode <= fchbd_mode_disk;
      end else begin
        mode <= fchbd_mode_memory;
      end
    end else if (mode_latched && mode != fchbd_mode_disk) begin
      mode <= io_configured ? fchbd_mode_io : fchbd_mode_memory;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      reset_seen <= 1'b0;
    end else if (!card_reset_pin) begin
      reset_seen <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      reset_count <= `FCHBD_RESET_CNT_ZERO;
      reset_done <= 1'b0;
    end else if (reset_count == `FCHBD_RESET_CYCLES) begin
      reset_done <= 1'b1;
    end else begin
      reset_count <= reset_count + 16'h0001;
    end
  end

  // ---------------------------------------------------------------------
  // Interrupt forms.
  // ---------------------------------------------------------------------
  logic [3:0] pulse_count;

  always_ff @(posedge clock) begin
    if (rst) begin
      pulse_count <= 4'h0;
    end else if (irq_event && !irq_level_mode) begin
      pulse_count <= `FCHBD_PULSE_CYCLES;
    end else if (pulse_count != 4'h0) begin
      pulse_count <= pulse_count - 4'h1;
    end
  end

  logic io_irq_low;
  assign io_irq_low = irq_level_mode ? irq_active : (pulse_count != 4'h0);

  always_ff @(posedge clock) begin
    if (rst) begin
      ready_busy_n <= 1'b0;
      disk_interrupt <= 1'b0;
    end else begin
      disk_interrupt <= (mode == fchbd_mode_disk) && irq_active;
      if (mode == fchbd_mode_io && reset_done) begin
        ready_busy_n <= !io_irq_low;
      end else if (!reset_seen && card_reset_pin) begin
        ready_busy_n <= 1'b1;
      end else begin
        ready_busy_n <= reset_done && !card_busy;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Address, target and lane decode.
  // ---------------------------------------------------------------------
  logic selected;
  logic read_active;

  always_comb begin
    target = fchbd_tgt_none;
    reg_address = address;
    selected = 1'b0;
    unique case (mode)
      fchbd_mode_disk: begin
        reg_address = {{(`FCHBD_ADDR_W-`FCHBD_TF_ADDR_W){1'b0}},
                       address[`FCHBD_TF_ADDR_W-1:0]};
        if (!cs0_n) begin
          target = fchbd_tgt_taskfile;
        end else if (!cs1_n) begin
          target = fchbd_tgt_control;
        end
        selected = !cs0_n || !cs1_n;
      end
      fchbd_mode_io: begin
        selected = !ce1_n || !ce2_n;
        if (selected) begin
          target = (!iord_n || !io_write_strobe_n_n) ? fchbd_tgt_io_port
                                        : fchbd_tgt_attribute;
        end
      end
      default: begin
        selected = !ce1_n || !ce2_n;
        if (selected) begin
          target = reg_n ? fchbd_tgt_common
                         : fchbd_tgt_attribute;
        end
      end
    endcase
  end

  always_comb begin
    lane = fchbd_lane_none;
    if (mode == fchbd_mode_disk) begin
      lane = (target == fchbd_tgt_taskfile && data_transfer)
             ? fchbd_lane_word : fchbd_lane_low;
    end else if (!ce1_n && !ce2_n) begin
      lane = fchbd_lane_word;
    end else if (!ce2_n) begin
      lane = fchbd_lane_high;
    end else if (!ce1_n) begin
      lane = fchbd_lane_low;
    end
  end

  always_comb begin
    read_active = 1'b0;
    unique case (mode)
      fchbd_mode_memory: read_active = !rd_n;
      fchbd_mode_io: read_active = (!rd_n && target == fchbd_tgt_attribute)
                                   || !iord_n;
      default: read_active = !iord_n;
    endcase
  end

  // ---------------------------------------------------------------------
  // Read data steering.
  // ---------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      data_out <= 16'h0000;
      data_oe <= 16'h0000;
    end else if (selected && read_active && reset_done) begin
      unique case (lane)
        fchbd_lane_word: begin
          data_out <= read_word;
          data_oe <= 16'hffff;
        end
        fchbd_lane_high: begin
          data_out <= {read_word[`FCHBD_MSB_HIGH:`FCHBD_LSB_HIGH], 8'h00};
          data_oe <= 16'hff00;
        end
        fchbd_lane_low: begin
          data_out <= (address[0] && mode != fchbd_mode_disk)
            ? {8'h00, read_word[`FCHBD_MSB_HIGH:`FCHBD_LSB_HIGH]}
            : {8'h00, read_word[`FCHBD_MSB_LOW:0]};
          data_oe <= 16'h00ff;
        end
        default: begin
          data_out <= 16'h0000;
          data_oe <= 16'h0000;
        end
      endcase
    end else begin
      data_out <= 16'h0000;
      data_oe <= 16'h0000;
    end
  end

  // ---------------------------------------------------------------------
  // Write capture on strobe trailing edge.
  // ---------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      io_write_strobe_n_prev <= 1'b1;
      we_prev <= 1'b1;
    end else begin
      io_write_strobe_n_prev <= io_write_strobe_n_n;
      we_prev <= we_n;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      write_pulse <= 1'b0;
      write_word <= 16'h0000;
    end else begin
      write_pulse <= selected && reset_done &&
        ((io_write_strobe_n_n && !io_write_strobe_n_prev) ||
         (mode != fchbd_mode_disk && we_n && !we_prev));
      if (lane == fchbd_lane_high || (lane == fchbd_lane_low &&
          address[0] && mode != fchbd_mode_disk)) begin
        write_word <= {data_in[`FCHBD_MSB_HIGH:`FCHBD_LSB_HIGH],
                       data_in[`FCHBD_MSB_LOW:0]};
      end else begin
        write_word <= data_in;
      end
    end
  end
endmodule // fchbd_host_port
`default_nettype wire

// ===== verilog/fchbd_defines.svh
`ifndef FCHBD_DEFINES_SVH
`define FCHBD_DEFINES_SVH
`define FCHBD_RESET_CYCLES 16'h0020
`define FCHBD_ADDR_W 11
`define FCHBD_TF_ADDR_W 3
`define FCHBD_MSB_LOW 7
`define FCHBD_MSB_HIGH 15
`define FCHBD_LSB_HIGH 8
`define FCHBD_PULSE_CYCLES 4'h4
`define FCHBD_RESET_CNT_ZERO 16'h0000
`define FCHBD_SYNC_SETTLE 16'h0002
`endif

// ===== verilog/fchbd_pkg.sv
package fchbd_pkg;
  typedef enum logic [1:0] {
    fchbd_mode_memory,
    fchbd_mode_io,
    fchbd_mode_disk
  } fchbd_mode_t;
  typedef enum logic [2:0] {
    fchbd_tgt_none,
    fchbd_tgt_common,
    fchbd_tgt_attribute,
    fchbd_tgt_io_port,
    fchbd_tgt_taskfile,
    fchbd_tgt_control
  } fchbd_target_t;
  typedef enum logic [1:0] {
    fchbd_lane_none,
    fchbd_lane_word,
    fchbd_lane_low,
    fchbd_lane_high
  } fchbd_lane_t;
endpackage

// ===== verilog/fchbd_sync.sv
`timescale 1ns/1ps
`default_nettype none
module fchbd_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Asynchronous levels in, clocked levels out.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;

  always_ff @(posedge clock) begin
    if (rst) begin
      stage_one <= '1;
      sync_out <= '1;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule // fchbd_sync
`default_nettype wire

// ===== verif/fchbd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fchbd_host_model (
  // Card side.
  input wire logic clock,
  input wire logic [15:0] data_out,
  input wire logic [15:0] data_oe,
  input wire logic ready_busy_n,
  // Host side.
  output logic [15:0] data_bus,
  output logic ready_line
);
  logic [15:0] last = 16'h0000;
  // A released data line shows the inverse of its last level.
  always_ff @(posedge clock) begin
    last <= data_bus;
  end
  assign data_bus = (data_out & data_oe) | (~last & ~data_oe);
  assign ready_line = ready_busy_n;
endmodule  // fchbd_host_model
`default_nettype wire

// ===== verif/fchbd_host_port_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fchbd_host_port_chk
  import fchbd_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Host pins, plus the card side irq_level_mode control.
  input wire logic card_reset_pin,
  input wire logic read_strobe_n,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic space_select_n,
  input wire logic card_enable_low_n,
  input wire logic card_enable_high_n,
  input wire logic taskfile_select_n,
  input wire logic control_block_select_n,
  input wire logic irq_level_mode,
  // Design outputs.
  input wire logic [15:0] data_oe,
  input wire logic ready_busy_n,
  input wire logic disk_interrupt,
  input wire fchbd_mode_t mode,
  input wire fchbd_target_t target,
  input wire fchbd_lane_t lane,
  input wire logic write_pulse
);
  logic act;
  logic ok;
  logic [4:0] hist;
  logic [1:0] rst_d;
  assign act = ((!card_enable_low_n || !card_enable_high_n) &&
    (!read_strobe_n || !io_read_strobe_n)) || (!io_read_strobe_n &&
    (!taskfile_select_n || !control_block_select_n));
  assign ok = !rst_d[1];
  always_ff @(posedge clock) begin
    hist <= rst ? 5'h00 : {hist[3:0], act};
    rst_d <= {rst_d[0], rst};
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_rst_quiet: assert property (disable iff (1'b0)
    rst && rst_d[0] |-> !ready_busy_n && data_oe == 16'h0000)
    else $error("outputs active in reset");
  a_busy_hold: assert property (
    $fell(rst) && !card_reset_pin |-> !ready_busy_n [*8])
    else $error("ready too early after reset");
  a_irq_pulse: assert property (
    $fell(ready_busy_n) && mode == fchbd_mode_io && !irq_level_mode
    |-> ##3 !ready_busy_n ##1 ready_busy_n) else $error("bad irq pulse");
  a_disk_irq: assert property (disk_interrupt |->
    mode == fchbd_mode_disk) else $error("disk irq outside disk mode");
  a_oe_cause: assert property (data_oe != 16'h0000 |->
    act || hist != 5'h00) else $error("bus driven without read");
  a_lane_high: assert property (ok && mode != fchbd_mode_disk &&
    lane == fchbd_lane_high |-> $past(card_enable_low_n, 2) &&
    !$past(card_enable_high_n, 2)) else $error("high lane wrong");
  a_lane_low: assert property (ok && mode != fchbd_mode_disk &&
    lane == fchbd_lane_low |-> !$past(card_enable_low_n, 2) &&
    $past(card_enable_high_n, 2)) else $error("low lane wrong");
  a_tgt_common: assert property (ok &&
    target == fchbd_tgt_common |-> $past(space_select_n, 2))
    else $error("common target wrong");
  a_tgt_task: assert property (ok &&
    target == fchbd_tgt_taskfile |-> !$past(taskfile_select_n, 2))
    else $error("taskfile target wrong");
  a_tgt_ctrl: assert property (ok &&
    target == fchbd_tgt_control |-> !$past(control_block_select_n, 2))
    else $error("control target wrong");
  a_wp_single: assert property (write_pulse |=> !write_pulse)
    else $error("write pulse too long");
  a_wp_rise: assert property (write_pulse |->
    $past(io_write_strobe_n, 3)) else $error("write before strobe rise");
endmodule  // fchbd_host_port_chk
bind fchbd_host_port fchbd_host_port_chk chk_i (.clock, .rst,
  .card_reset_pin, .read_strobe_n, .io_read_strobe_n, .io_write_strobe_n,
  .space_select_n, .card_enable_low_n, .card_enable_high_n,
  .taskfile_select_n, .control_block_select_n, .irq_level_mode, .data_oe,
  .ready_busy_n, .disk_interrupt, .mode, .target, .lane, .write_pulse);
`default_nettype wire

// ===== verif/flash_card_host_bus_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flash_card_host_bus_decode_tb
  import fchbd_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic card_reset_pin = 1'b1;
  logic read_strobe_n = 1'b1;
  logic io_read_strobe_n = 1'b1;
  logic io_write_strobe_n = 1'b1;
  logic space_select_n = 1'b1;
  logic [3:0] sel_n = 4'hf;
  logic [10:0] address = 11'h000;
  logic [15:0] data_in = 16'h0000;
  logic io_configured = 1'b0;
  logic irq_level_mode = 1'b0;
  logic irq_event = 1'b0;
  logic irq_active = 1'b0;
  logic card_busy = 1'b0;
  logic data_transfer = 1'b0;
  logic [15:0] read_word = 16'ha53c;
  logic [15:0] data_out, data_oe, data_bus, write_word;
  logic [10:0] reg_address;
  logic ready_busy_n, disk_interrupt, write_pulse, ready_line;
  fchbd_mode_t mode;
  fchbd_target_t target;
  fchbd_lane_t lane;
  int fail_count = 0;
  int tests_run = 0;
  always #5 clock = ~clock;
  fchbd_host_port fchbd_host_port_i (.clock(clock), .rst(rst),
    .card_reset_pin(card_reset_pin), .read_strobe_n(read_strobe_n),
    .io_read_strobe_n(io_read_strobe_n), .write_enable_n(1'b1),
    .io_write_strobe_n(io_write_strobe_n), .space_select_n(space_select_n),
    .card_enable_low_n(sel_n[0]), .card_enable_high_n(sel_n[1]),
    .taskfile_select_n(sel_n[2]), .control_block_select_n(sel_n[3]),
    .address(address), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .ready_busy_n(ready_busy_n), .mode(mode),
    .disk_interrupt(disk_interrupt), .io_configured(io_configured),
    .irq_level_mode(irq_level_mode), .irq_event(irq_event),
    .irq_active(irq_active), .card_busy(card_busy), .lane(lane),
    .data_transfer(data_transfer), .read_word(read_word), .target(target),
    .reg_address(reg_address), .write_pulse(write_pulse),
    .write_word(write_word));
  fchbd_host_model fchbd_host_model_i (.clock(clock), .data_out(data_out),
    .data_oe(data_oe), .ready_busy_n(ready_busy_n), .data_bus(data_bus),
    .ready_line(ready_line));
  task automatic chk(input string name, input logic [15:0] seen,
      input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic do_reset(input logic pin, input logic rd_n);
    rst <= 1'b1;
    card_reset_pin <= pin;
    read_strobe_n <= rd_n;
    cyc(4);
    rst <= 1'b0;
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 40; i++) begin
      #1;
      if (ready_busy_n === 1'b1) break;
      @(posedge clock);
    end
    chk("ready", 16'(ready_line), 16'h0001);
    @(posedge clock);
  endtask
  task automatic rd(input logic [3:0] sel, input logic io, input logic ss,
      input logic [2:0] a, input fchbd_target_t tgt, input logic [15:0] exp,
      input logic [15:0] msk);
    sel_n <= sel;
    space_select_n <= ss;
    address <= {8'h00, a};
    if (io) io_read_strobe_n <= 1'b0;
    else read_strobe_n <= 1'b0;
    cyc(5);
    #1 chk("target", 16'(target), 16'(tgt));
    chk("reg address", 16'(reg_address), 16'(a));
    chk("lanes", data_oe, msk);
    chk("read data", data_bus & msk, exp);
    @(posedge clock);
    sel_n <= 4'hf;
    io_read_strobe_n <= 1'b1;
    if (!io) read_strobe_n <= 1'b1;
    cyc(6);
  endtask
  task automatic t_reset();
    do_reset(1'b1, 1'b1);
    cyc(3);
    #1 chk("never busy", 16'(ready_busy_n), 16'h0001);
    cyc(1);
    do_reset(1'b0, 1'b1);
    repeat (30) begin
      cyc(1);
      #1 chk("busy after reset", 16'(ready_busy_n), 16'h0000);
    end
    wait_ready();
    card_busy <= 1'b1;
    cyc(4);
    #1 chk("busy", 16'(ready_busy_n), 16'h0000);
    cyc(1);
    card_busy <= 1'b0;
    wait_ready();
  endtask
  task automatic t_mem();
    rd(4'hc, 1'b0, 1'b1, 3'h0, fchbd_tgt_common, 16'ha53c, 16'hffff);
    rd(4'he, 1'b0, 1'b1, 3'h0, fchbd_tgt_common, 16'h003c, 16'h00ff);
    rd(4'he, 1'b0, 1'b1, 3'h1, fchbd_tgt_common, 16'h00a5, 16'h00ff);
    rd(4'hd, 1'b0, 1'b1, 3'h0, fchbd_tgt_common, 16'ha500, 16'hff00);
    rd(4'hc, 1'b0, 1'b0, 3'h0, fchbd_tgt_attribute, 16'ha53c, 16'hffff);
  endtask
  task automatic t_io();
    int n = 0;
    io_configured <= 1'b1;
    cyc(4);
    #1 chk("io mode", 16'(mode), 16'(fchbd_mode_io));
    cyc(1);
    irq_event <= 1'b1;
    cyc(1);
    irq_event <= 1'b0;
    repeat (12) begin
      cyc(1);
      #1 n += (ready_busy_n === 1'b0);
    end
    chk("irq pulse", 16'(n), 16'h0004);
    cyc(1);
    irq_level_mode <= 1'b1;
    irq_active <= 1'b1;
    cyc(6);
    #1 chk("irq level", 16'(ready_busy_n), 16'h0000);
    cyc(1);
    irq_active <= 1'b0;
    cyc(6);
    rd(4'hc, 1'b1, 1'b0, 3'h0, fchbd_tgt_io_port, 16'ha53c, 16'hffff);
    rd(4'hc, 1'b0, 1'b0, 3'h0, fchbd_tgt_attribute, 16'ha53c, 16'hffff);
    sel_n <= 4'hc;
    space_select_n <= 1'b0;
    data_in <= 16'h5aa5;
    io_write_strobe_n <= 1'b0;
    n = 0;
    for (int i = 0; i < 14; i++) begin
      cyc(1);
      if (i == 3) io_write_strobe_n <= 1'b1;
      #1 n += write_pulse;
      if (write_pulse) chk("write word", write_word, 16'h5aa5);
    end
    chk("write pulses", 16'(n), 16'h0001);
    sel_n <= 4'hf;
  endtask
  task automatic t_disk();
    cyc(1);
    io_configured <= 1'b0;
    do_reset(1'b0, 1'b0);
    wait_ready();
    chk("disk mode", 16'(mode), 16'(fchbd_mode_disk));
    rd(4'hb, 1'b1, 1'b1, 3'h5, fchbd_tgt_taskfile, 16'h003c, 16'h00ff);
    rd(4'h7, 1'b1, 1'b1, 3'h6, fchbd_tgt_control, 16'h003c, 16'h00ff);
    data_transfer <= 1'b1;
    rd(4'hb, 1'b1, 1'b1, 3'h0, fchbd_tgt_taskfile, 16'ha53c, 16'hffff);
    irq_active <= 1'b1;
    cyc(4);
    #1 chk("disk irq", 16'(disk_interrupt), 16'h0001);
  endtask
  initial begin
    t_reset();
    t_mem();
    t_io();
    t_disk();
    print_verdict();
  end
  initial begin
    #200000;
    fail_count++;
    print_verdict();
  end
endmodule  // flash_card_host_bus_decode_tb
`default_nettype wire
